// ===== rtl/clg_top.sv
/*
  six configurable logic gate instances behind an AXI4-Lite slave.
  each instance evaluates its selected operation once per clock into a result
  register that other blocks read on gate_result.
  assumes a single 50 MHz clock, synchronous active-high reset, and a master
  that keeps AXI4-Lite valid/ready discipline.
*/
// Functional notes
// RULE1: six identical independent gate instances
// RULE2: and gives on only when both on
// RULE3: nand gives off only when both on
// RULE4: or on if any; nor complement
// RULE5: xor on if differ; xnor if equal
// RULE6: invert gives not a, b ignored
// RULE7: greater, greater-equal, less, less-equal compares
// RULE8: equal and not-equal compares
// RULE9: abs, negated abs, negate of a
// RULE10: sum and a minus b
// RULE11: product and quotient of a, b
// RULE12: filter: a input, b gain, result output
// RULE13: sr flip-flop, reset dominant, holds otherwise
// RULE14: latch a on b rising or falling
// RULE15: boolean or numeric by mode, false preset
// RULE16: mode resets to and
// RULE17: filter is first-order low-pass step
// RULE18: divide by zero saturates with a's sign
`timescale 1ns/1ps
module clg_top
  import clg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [5:0][15:0] gate_result
);

  // address decode shared by both channels
  function automatic clg_dec_s clg_decode(input logic [7:0] addr);
    clg_dec_s d;
    d.inst = addr[6:4];
    d.sel = addr[3:2];
    d.hit = (addr[7] == 1'b0) && (addr[6:4] < 3'(CLG_NUM_INST)) && (addr[1:0] == 2'h0);
    return d;
  endfunction

  // clamp a wide signed value into the operand range
  function automatic logic signed [15:0] clg_sat(input logic signed [33:0] v);
    logic signed [15:0] r;
    r = v[15:0];
    if (v > CLG_MAX34)
      r = CLG_MAX;
    else if (v < CLG_MIN34)
      r = CLG_MIN;
    return r;
  endfunction

  // one processing step of an instance
  function automatic logic signed [15:0] clg_eval(input clg_cfg_s c,
                                                  input logic signed [15:0] res,
                                                  input logic prevb);
    logic signed [15:0] r;
    logic signed [33:0] ae;
    logic signed [33:0] be;
    logic signed [33:0] re;
    logic signed [33:0] gain;
    logic signed [33:0] prod;
    logic ab;
    logic bb;
    logic cmp;
    r = res;
    ae = 34'(c.opa);
    be = 34'(c.opb);
    re = 34'(res);
    gain = c.opb[15] ? 34'sh0_0000_0000 : be;
    prod = (ae - re) * gain;
    ab = (c.opa != CLG_FALSE); // any nonzero operand is on [RULE15]
    bb = (c.opb != CLG_FALSE);
    cmp = 1'b0;
    case (clg_mode_e'(c.mode))
      CLG_OP_AND: cmp = ab & bb; // [RULE2]
      CLG_OP_NAND: cmp = ~(ab & bb); // [RULE3]
      CLG_OP_OR: cmp = ab | bb; // [RULE4]
      CLG_OP_NOR: cmp = ~(ab | bb); // [RULE4]
      CLG_OP_XOR: cmp = ab ^ bb; // [RULE5]
      CLG_OP_XNOR: cmp = ~(ab ^ bb); // [RULE5]
      CLG_OP_NOT: cmp = ~ab; // [RULE6]
      CLG_OP_GT: cmp = c.opa > c.opb; // [RULE7]
      CLG_OP_GE: cmp = c.opa >= c.opb; // [RULE7]
      CLG_OP_LT: cmp = c.opa < c.opb; // [RULE7]
      CLG_OP_LE: cmp = c.opa <= c.opb; // [RULE7]
      CLG_OP_EQ: cmp = c.opa == c.opb; // [RULE8]
      CLG_OP_NE: cmp = c.opa != c.opb; // [RULE8]
      default: cmp = 1'b0;
    endcase
    r = cmp ? CLG_TRUE : CLG_FALSE; // boolean result for gates and compares [RULE15]
    case (clg_mode_e'(c.mode))
      CLG_OP_ABS: r = clg_sat(ae[33] ? -ae : ae); // [RULE9]
      CLG_OP_NABS: r = clg_sat(ae[33] ? ae : -ae); // [RULE9]
      CLG_OP_NEG: r = clg_sat(-ae); // [RULE9]
      CLG_OP_ADD: r = clg_sat(ae + be); // [RULE10]
      CLG_OP_SUB: r = clg_sat(ae - be); // [RULE10]
      CLG_OP_MUL: r = clg_sat(ae * be); // [RULE11]
      CLG_OP_DIV:
      begin
        if (c.opb == CLG_FALSE)
          r = c.opa[15] ? CLG_MIN : CLG_MAX; // [RULE18]
        else
          r = clg_sat(ae / be); // [RULE11]
      end
      // move toward a by (a - res) * gain / 2^15 each step [RULE12] [RULE17]
      CLG_OP_FILT: r = clg_sat(re + (prod >>> CLG_GAIN_SHIFT));
      CLG_OP_SRFF:
      begin
        if (bb)
          r = CLG_FALSE; // reset dominates [RULE13]
        else if (ab)
          r = CLG_TRUE; // [RULE13]
        else
          r = res; // [RULE13]
      end
      CLG_OP_PLAT: r = (bb && !prevb) ? c.opa : res; // [RULE14]
      CLG_OP_NLAT: r = (!bb && prevb) ? c.opa : res; // [RULE14]
      default: r = r;
    endcase
    return r;
  endfunction

  // configuration, results and write channel state
  clg_cfg_s cfg_r [CLG_NUM_INST];
  logic signed [15:0] res_r [CLG_NUM_INST];
  logic prevb_r [CLG_NUM_INST];
  clg_wst_e wst_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic rvalid_r;
  logic aw_ok;
  logic w_ok;
  logic do_wr;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  clg_dec_s wdec;
  clg_dec_s rdec;

  // write channel handshakes; address and data may come in either order
  assign s_axi_awready = (wst_r == CLG_W_IDLE) && !aw_got_r;
  assign s_axi_wready = (wst_r == CLG_W_IDLE) && !w_got_r;
  assign aw_ok = s_axi_awvalid && s_axi_awready;
  assign w_ok = s_axi_wvalid && s_axi_wready;
  assign do_wr = (wst_r == CLG_W_IDLE) && (aw_got_r || aw_ok) && (w_got_r || w_ok);
  assign wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_got_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;
  assign wdec = clg_decode(wr_addr);
  assign rdec = clg_decode(s_axi_araddr);
  assign s_axi_bvalid = (wst_r == CLG_W_RESP);
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // write channel state machine and holding registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wst_r <= CLG_W_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bresp_r <= CLG_RESP_OKAY;
    end
    else
    begin
      case (wst_r)
        CLG_W_IDLE:
        begin
          if (do_wr)
          begin
            wst_r <= CLG_W_RESP;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bresp_r <= wdec.hit ? CLG_RESP_OKAY : CLG_RESP_SLVERR;
          end
          else
          begin
            if (aw_ok)
            begin
              aw_got_r <= 1'b1;
              aw_addr_r <= s_axi_awaddr;
            end
            if (w_ok)
            begin
              w_got_r <= 1'b1;
              w_data_r <= s_axi_wdata;
              w_strb_r <= s_axi_wstrb;
            end
          end
        end
        CLG_W_RESP:
        begin
          if (s_axi_bready)
            wst_r <= CLG_W_IDLE;
        end
        default: wst_r <= CLG_W_IDLE;
      endcase
    end
  end

  // software writes into the configuration; results are read-only
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < CLG_NUM_INST; i++)
    begin
      if (rst)
      begin
        cfg_r[i].mode <= CLG_MODE_RST; // [RULE16]
        cfg_r[i].opa <= CLG_FALSE; // [RULE15]
        cfg_r[i].opb <= CLG_FALSE;
      end
      else if (do_wr && wdec.hit && (wdec.inst == 3'(i)))
      begin
        if (wdec.sel == CLG_SEL_MODE && wr_strb[0])
          cfg_r[i].mode <= wr_data[4:0];
        if (wdec.sel == CLG_SEL_OPA && wr_strb[0])
          cfg_r[i].opa[7:0] <= wr_data[7:0];
        if (wdec.sel == CLG_SEL_OPA && wr_strb[1])
          cfg_r[i].opa[15:8] <= wr_data[15:8];
        if (wdec.sel == CLG_SEL_OPB && wr_strb[0])
          cfg_r[i].opb[7:0] <= wr_data[7:0];
        if (wdec.sel == CLG_SEL_OPB && wr_strb[1])
          cfg_r[i].opb[15:8] <= wr_data[15:8];
      end
    end
  end

  // read channel, one word answered the cycle after the address is taken
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= CLG_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= rdec.hit ? CLG_RESP_OKAY : CLG_RESP_SLVERR;
      rdata_r <= 32'h0000_0000;
      if (rdec.hit)
      begin
        case (rdec.sel)
          CLG_SEL_MODE: rdata_r <= {27'h0, cfg_r[rdec.inst].mode};
          CLG_SEL_OPA: rdata_r <= {16'h0000, cfg_r[rdec.inst].opa};
          CLG_SEL_OPB: rdata_r <= {16'h0000, cfg_r[rdec.inst].opb};
          default: rdata_r <= {16'h0000, res_r[rdec.inst]};
        endcase
      end
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // six independent processing instances, one step per clock [RULE1]
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < CLG_NUM_INST; i++)
    begin
      if (rst)
      begin
        res_r[i] <= CLG_FALSE; // [RULE15]
        prevb_r[i] <= 1'b0;
      end
      else
      begin
        res_r[i] <= clg_eval(cfg_r[i], res_r[i], prevb_r[i]);
        prevb_r[i] <= (cfg_r[i].opb != CLG_FALSE);
      end
    end
  end

  // results toward the other drive blocks
  always_comb
  begin
    for (int i = 0; i < CLG_NUM_INST; i++)
      gate_result[i] = res_r[i];
  end

  // checks on the instance that each scenario drives, and on the bus
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_AND_TRUTH: assert property ( // [RULE2]
    cfg_r[0].mode == CLG_OP_AND |=>
      res_r[0] == (($past(cfg_r[0].opa) != 0 && $past(cfg_r[0].opb) != 0) ? CLG_TRUE : CLG_FALSE))
    else $error("and result wrong");
  AST_NAND_TRUTH: assert property ( // [RULE3]
    cfg_r[1].mode == CLG_OP_NAND && cfg_r[1].opa != 0 && cfg_r[1].opb == 0 |=> res_r[1] == CLG_TRUE)
    else $error("nand result wrong");
  AST_NOT_IGNORES_B: assert property ( // [RULE6]
    cfg_r[0].mode == CLG_OP_NOT |=>
      res_r[0] == (($past(cfg_r[0].opa) == 0) ? CLG_TRUE : CLG_FALSE))
    else $error("invert result wrong");
  AST_GE_EQUAL: assert property ( // [RULE7]
    cfg_r[2].mode == CLG_OP_GE && cfg_r[2].opa == cfg_r[2].opb |=> res_r[2] == CLG_TRUE)
    else $error("greater-equal result wrong");
  AST_ADD_SAT: assert property ( // [RULE10]
    cfg_r[4].mode == CLG_OP_ADD && cfg_r[4].opa == CLG_MAX && cfg_r[4].opb > 0
      |=> res_r[4] == CLG_MAX)
    else $error("sum not saturated");
  AST_DIV_ZERO: assert property ( // [RULE18]
    cfg_r[1].mode == CLG_OP_DIV && cfg_r[1].opb == 0 && cfg_r[1].opa < 0 |=> res_r[1] == CLG_MIN)
    else $error("divide by zero not saturated");
  AST_SR_RESET: assert property ( // [RULE13]
    cfg_r[3].mode == CLG_OP_SRFF && cfg_r[3].opb != 0 |=> res_r[3] == CLG_FALSE)
    else $error("flip-flop reset failed");
  AST_SR_HOLD: assert property ( // [RULE13]
    (cfg_r[3].mode == CLG_OP_SRFF && cfg_r[3].opa == 0 && cfg_r[3].opb == 0) [*2] |->
      $stable(res_r[3]))
    else $error("flip-flop did not hold");
  AST_LATCH_RISE: assert property ( // [RULE14]
    cfg_r[4].mode == CLG_OP_PLAT && cfg_r[4].opb != 0 && !prevb_r[4] |=>
      res_r[4] == $past(cfg_r[4].opa) ##1 (cfg_r[4].mode != CLG_OP_PLAT || $stable(res_r[4])))
    else $error("rising latch wrong");
  AST_FILT_ZERO_GAIN: assert property ( // [RULE17]
    cfg_r[5].mode == CLG_OP_FILT && cfg_r[5].opb == 0 |=> $stable(res_r[5]))
    else $error("filter moved with zero gain");
  AST_RESET_MODE: assert property ( // [RULE16]
    disable iff (1'b0) $past(rst) |-> cfg_r[5].mode == CLG_OP_AND && cfg_r[0].mode == CLG_OP_AND)
    else $error("mode not and after reset");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  COV_SR_SET: cover property (cfg_r[3].mode == CLG_OP_SRFF ##1 res_r[3] == CLG_TRUE);
  COV_DIV_ZERO: cover property (cfg_r[1].mode == CLG_OP_DIV && cfg_r[1].opb == 0);
  COV_LATCH_FALL: cover property (cfg_r[4].mode == CLG_OP_NLAT && prevb_r[4] && cfg_r[4].opb == 0);
  COV_WRITE_RESP: cover property (s_axi_bvalid && s_axi_bready);

endmodule

// ===== rtl/clg_pkg.sv
/*
  shared constants and types for the configurable logic gate block:
  register map, reset values, operation codes and carrier structs.
  assumes a 32-bit AXI4-Lite register bus and 16-bit signed operands.
*/
package clg_pkg;

  // instance count and operand width
  localparam int CLG_NUM_INST = 6;
  localparam int CLG_DW = 16;

  // register map: instance base is index times stride, then a word per register
  localparam int CLG_ADDR_W = 8;
  localparam logic [7:0] CLG_INST_STRIDE = 8'h10;
  localparam logic [1:0] CLG_SEL_MODE = 2'h0;
  localparam logic [1:0] CLG_SEL_OPA = 2'h1;
  localparam logic [1:0] CLG_SEL_OPB = 2'h2;
  localparam logic [1:0] CLG_SEL_RES = 2'h3;

  // bus answers
  localparam logic [1:0] CLG_RESP_OKAY = 2'h0;
  localparam logic [1:0] CLG_RESP_SLVERR = 2'h2;

  // values after reset and saturation limits
  localparam logic signed [15:0] CLG_FALSE = 16'sh0000;
  localparam logic signed [15:0] CLG_TRUE = 16'sh0001;
  localparam logic signed [15:0] CLG_MAX = 16'sh7FFF;
  localparam logic signed [15:0] CLG_MIN = 16'sh8000;
  localparam logic signed [33:0] CLG_MAX34 = 34'sh0_0000_7FFF;
  localparam logic signed [33:0] CLG_MIN34 = -34'sh0_0000_8000;
  localparam int CLG_GAIN_SHIFT = 15;

  // operation codes held in the function select register
  typedef enum logic [4:0] {
    CLG_OP_AND = 5'h00, CLG_OP_NAND = 5'h01, CLG_OP_OR = 5'h02, CLG_OP_NOR = 5'h03,
    CLG_OP_XOR = 5'h04, CLG_OP_XNOR = 5'h05, CLG_OP_NOT = 5'h06, CLG_OP_GT = 5'h07,
    CLG_OP_GE = 5'h08, CLG_OP_LT = 5'h09, CLG_OP_LE = 5'h0A, CLG_OP_EQ = 5'h0B,
    CLG_OP_NE = 5'h0C, CLG_OP_ABS = 5'h0D, CLG_OP_NABS = 5'h0E, CLG_OP_NEG = 5'h0F,
    CLG_OP_ADD = 5'h10, CLG_OP_SUB = 5'h11, CLG_OP_MUL = 5'h12, CLG_OP_DIV = 5'h13,
    CLG_OP_FILT = 5'h14, CLG_OP_SRFF = 5'h15, CLG_OP_PLAT = 5'h16, CLG_OP_NLAT = 5'h17
  } clg_mode_e;
  localparam logic [4:0] CLG_MODE_RST = 5'h00;

  // write channel state, one-hot
  typedef enum logic [1:0] {
    CLG_W_IDLE = 2'b01,
    CLG_W_RESP = 2'b10
  } clg_wst_e;

  // per-instance configuration
  typedef struct packed {
    logic [4:0] mode;
    logic signed [15:0] opa;
    logic signed [15:0] opb;
  } clg_cfg_s;

  // decoded register address
  typedef struct packed {
    logic hit;
    logic [2:0] inst;
    logic [1:0] sel;
  } clg_dec_s;

endpackage

// ===== dv/clg_reader.sv
/*
  partner model: a downstream block that samples the six gate results.
  assumes the same clock and synchronous reset as the gate block.
*/
`timescale 1ns/1ps
module clg_reader
  import clg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0][15:0] gate_result,
  output logic [5:0][15:0] seen_r
);
  // take every result once per clock, cleared on reset
  always_ff @(posedge clk)
    if (rst)
      seen_r <= '0;
    else
      seen_r <= gate_result;
endmodule

// ===== dv/tb.sv
/*
  self-checking bench: drives the register bus, checks the gate results.
  assumes the register map and operation codes of clg_pkg.
*/
`timescale 1ns/1ps
module tb
  import clg_pkg::*;
;
  logic clk;
  logic rst;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [5:0][15:0] gate_result;
  logic [5:0][15:0] seen;
  int n_fail, total_checks, cycles;
  int b_late;
  int pa[6] = '{5, -7, 32767, -32768, 300, -7};
  int pb[6] = '{5, 3, 1, -1, 200, 0};

  clg_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gate_result(gate_result));
  clg_reader reader (.clk(clk), .rst(rst), .gate_result(gate_result), .seen_r(seen));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] rs);
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (b_late == 0); // a late bready keeps the response pending a cycle
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid && !bready)
        bready <= 1'b1;
    end
    while (bvalid !== 1'b1 || bready !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [7:0] ad(int i, int s);
    return 8'(i * 16 + s * 4);
  endfunction

  task automatic wreg(int i, int s, int v);
    logic [1:0] r;
    wr(ad(i, s), 16'(v), r);
  endtask

  task automatic setg(int i, int m, int a, int b);
    wreg(i, 0, m);
    wreg(i, 1, a);
    wreg(i, 2, b);
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] sat(int v);
    return (v > 32767) ? 16'h7FFF : (v < -32768) ? 16'h8000 : 16'(v);
  endfunction

  // expected result of the stateless operations
  function automatic logic [15:0] expv(int m, int a, int b);
    logic x, y;
    x = (a != 0);
    y = (b != 0);
    case (m)
      0: return 16'(x & y);
      1: return 16'(!(x & y));
      2: return 16'(x | y);
      3: return 16'(!(x | y));
      4: return 16'(x ^ y);
      5: return 16'(x == y);
      6: return 16'(!x);
      7: return 16'(a > b);
      8: return 16'(a >= b);
      9: return 16'(a < b);
      10: return 16'(a <= b);
      11: return 16'(a == b);
      12: return 16'(a != b);
      13: return sat(a < 0 ? -a : a);
      14: return sat(a < 0 ? a : -a);
      15: return sat(-a);
      16: return sat(a + b);
      17: return sat(a - b);
      18: return sat(a * b);
      19: return (b == 0) ? (a < 0 ? 16'h8000 : 16'h7FFF) : sat(a / b);
      default: return 16'h0000;
    endcase
  endfunction

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++)
    begin
      chk(32'(gate_result[i]), 32'h0);
      rd(ad(i, 0), d, r);
      chk(d, 32'h0);
    end
    wr(ad(2, 1), 16'h8001, r);
    rd(ad(2, 1), d, r);
    chk(d, 32'h00008001);
    wstrb <= 4'h1;
    wr(ad(2, 1), 16'h7F22, r);
    wstrb <= 4'hF;
    rd(ad(2, 1), d, r);
    chk(d, 32'h00008022);
    rd(8'h60, d, r);
    chk(32'(r), 32'(CLG_RESP_SLVERR));
    chk(d, 32'h0);
    b_late = 1;
    wr(8'h60, 16'h1234, r);
    b_late = 0;
    chk(32'(r), 32'(CLG_RESP_SLVERR));
  endtask

  task automatic t_gates;
    int a, b;
    for (int m = 0; m < 6; m++)
      for (int k = 0; k < 4; k++)
      begin
        a = k[0] ? -3 : 0;
        b = k[1] ? 1 : 0;
        setg(m, m, a, b);
        step();
        chk(32'(gate_result[m]), 32'(expv(m, a, b)));
      end
  endtask

  task automatic t_arith;
    for (int m = 6; m < 20; m++)
      for (int p = 0; p < 6; p++)
      begin
        setg(m % 6, m, pa[p], pb[p]);
        step();
        chk(32'(gate_result[m % 6]), 32'(expv(m, pa[p], pb[p])));
      end
  endtask

  task automatic t_srff;
    int seq_a[4] = '{1, 1, 0, 0};
    int seq_b[4] = '{1, 0, 0, 1};
    int exp_r[4] = '{0, 1, 1, 0};
    wreg(3, 2, 1);
    wreg(3, 1, 0);
    wreg(3, 0, 21);
    step();
    chk(32'(gate_result[3]), 32'h0);
    for (int n = 0; n < 4; n++)
    begin
      wreg(3, 1, seq_a[n]);
      wreg(3, 2, seq_b[n]);
      step();
      chk(32'(gate_result[3]), 32'(exp_r[n]));
    end
  endtask

  task automatic t_latch;
    int sel[7] = '{0, 2, 1, 2, 0, 1, 2};
    int val[7] = '{22, 1, 9, 0, 23, 7, 1};
    int exp_r[7] = '{0, 5, 5, 5, 5, 5, 5};
    wreg(4, 0, 24);
    wreg(4, 2, 0);
    wreg(4, 1, 5);
    for (int n = 0; n < 7; n++)
    begin
      wreg(4, sel[n], val[n]);
      step();
      chk(32'(gate_result[4]), 32'(exp_r[n]));
    end
    wreg(4, 2, 0);
    step();
    chk(32'(gate_result[4]), 32'h7);
    chk(32'(seen[4]), 32'h7);
  endtask

  task automatic t_filter;
    int r;
    wreg(5, 0, 24);
    wreg(5, 1, 16384);
    wreg(5, 2, 16384);
    wreg(5, 0, 20);
    r = 0;
    for (int n = 0; n < 4; n++)
    begin
      r = r + (((16384 - r) * 16384) >>> 15);
      #1;
      chk(32'(gate_result[5]), 32'(16'(r)));
      @(posedge clk);
    end
    // settle, then freeze with zero gain and pull the input away
    repeat (20)
    begin
      r = r + (((16384 - r) * 16384) >>> 15);
      @(posedge clk);
    end
    wreg(5, 2, 0);
    wreg(5, 1, 0);
    step();
    chk(32'(gate_result[5]), 32'(16'(r)));
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    rst = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_gates();
    t_arith();
    t_srff();
    t_latch();
    t_filter();
    test_done();
  end
endmodule
